// >>> ext_access_consts.vh
// Constants for the extended register space access block.
// Assumes a classic Wishbone slave with 32-bit data and 16-bit registers.
`ifndef EXT_ACCESS_CONSTS_VH
`define EXT_ACCESS_CONSTS_VH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define OFS_ACCESS_CONTROL 8'h34
`define OFS_ADDRESS_DATA 8'h38
`define OFS_STATUS 8'h3C
`define OFS_WIDTH 8

// ----------------------------------------------------------------
// Control field layout
// ----------------------------------------------------------------
`define FUNC_HI 15
`define FUNC_LO 14
`define SEL_HI 4
`define SEL_LO 0
`define FUNC_ADDRESS 2'h0
`define FUNC_DATA 2'h1
`define FUNC_DATA_INC_ALL 2'h2
`define FUNC_DATA_INC_WR 2'h3
`define SPACE_VENDOR 5'h1F
`define SPACE_PMA 5'h01

// ----------------------------------------------------------------
// Storage and reset values
// ----------------------------------------------------------------
`define REG_WIDTH 16
`define STORE_AW 8
`define CTRL_RESET 16'h0000
`define ADDR_RESET 16'h0000
`define ADDR_STEP 16'h0001
`define ZERO16 16'h0000
`define ZERO32 32'h00000000

`endif

// >>> ext_space_ram.v
// Small synchronous memory holding one extended register space.
// Read data comes from a register one cycle after the address.
`timescale 1ns/1ps
`default_nettype none
`include "ext_access_consts.vh"

module ext_space_ram (
    input wire clk_sys_in, // System clock
    input wire we_in, // Write strobe
    input wire [`STORE_AW-1:0] addr_in, // Word address
    input wire [`REG_WIDTH-1:0] wdata_in, // Write data
    output reg [`REG_WIDTH-1:0] rdata_out // Registered read data
);
    reg [`REG_WIDTH-1:0] mem [0:(1<<`STORE_AW)-1];

    // No reset on the array; contents start undefined like real RAM
    always @(posedge clk_sys_in) begin
        if (we_in) begin
            mem[addr_in] <= wdata_in;
        end
        rdata_out <= mem[addr_in];
    end
endmodule // ext_space_ram
`default_nettype wire

// >>> ext_wb_decode.v
// Decodes a classic Wishbone request into one-hot register selects.
// Assumes cyc, stb and address are held steady until acknowledged.
`timescale 1ns/1ps
`default_nettype none
`include "ext_access_consts.vh"

module ext_wb_decode (
    input wire [`OFS_WIDTH-1:0] adr_in, // Byte address
    output wire sel_ctrl_out, // Control register hit
    output wire sel_data_out, // Address/data register hit
    output wire sel_stat_out // Status register hit
);
    assign sel_ctrl_out = (adr_in == `OFS_ACCESS_CONTROL);
    assign sel_data_out = (adr_in == `OFS_ADDRESS_DATA);
    assign sel_stat_out = (adr_in == `OFS_STATUS);
endmodule // ext_wb_decode
`default_nettype wire

// >>> ext_access_top.v
// Indirect access to a vendor and a PMA extended register space.
// Assumes a classic Wishbone master with 32-bit data; data in bits 15:0.
`timescale 1ns/1ps
`default_nettype none
`include "ext_access_consts.vh"

module ext_access_top (
    input wire clk_sys_in, // System clock, 40 MHz
    input wire rst_in, // Asynchronous reset, active high
    input wire wb_cyc_in, // Wishbone cycle
    input wire wb_stb_in, // Wishbone strobe
    input wire wb_we_in, // Wishbone write enable
    input wire [`OFS_WIDTH-1:0] wb_adr_in, // Wishbone byte address
    input wire [3:0] wb_sel_in, // Wishbone byte selects
    input wire [31:0] wb_dat_in, // Wishbone write data
    output reg [31:0] wb_dat_out, // Wishbone read data
    output reg wb_ack_out, // Wishbone acknowledge
    output reg wb_err_out // Wishbone error, unmapped address
);
    // ----------------------------------------------------------------
    // Local state
    // ----------------------------------------------------------------
    localparam ST_IDLE = 2'h0;
    localparam ST_READ = 2'h1;
    localparam ST_DONE = 2'h2;

    reg [1:0] state_q;
    reg [`REG_WIDTH-1:0] ext_access_control_q;
    reg [`REG_WIDTH-1:0] ext_address_q;
    wire sel_pma;
    reg [`REG_WIDTH-1:0] ignored_count_q;
    wire sel_ctrl;
    wire sel_data;
    wire sel_stat;
    wire req;
    wire [1:0] func;
    wire [4:0] space_select;
    wire space_ok;
    wire lo_wr;
    wire [`REG_WIDTH-1:0] wr16;
    wire vendor_we;
    wire pma_we;
    wire [`REG_WIDTH-1:0] vendor_rd;
    wire [`REG_WIDTH-1:0] pma_rd;
    wire data_access;
    reg bump;

    // True when the select field names one of the two spaces
    function space_valid;
        input [4:0] s;
        begin
            space_valid = (s == `SPACE_VENDOR) || (s == `SPACE_PMA);
        end
    endfunction

    ext_wb_decode u_dec (
        .adr_in(wb_adr_in),
        .sel_ctrl_out(sel_ctrl),
        .sel_data_out(sel_data),
        .sel_stat_out(sel_stat)
    );

    assign req = wb_cyc_in && wb_stb_in && (state_q == ST_IDLE);
    assign func = ext_access_control_q[`FUNC_HI:`FUNC_LO];
    assign space_select = ext_access_control_q[`SEL_HI:`SEL_LO];
    assign space_ok = space_valid(space_select);
    assign sel_pma = (space_select == `SPACE_PMA);
    assign lo_wr = wb_sel_in[0] && wb_sel_in[1];
    assign wr16 = wb_dat_in[`REG_WIDTH-1:0];
    assign data_access = req && sel_data && space_ok && (func != `FUNC_ADDRESS);

    // ----------------------------------------------------------------
    // Extended register storage
    // ----------------------------------------------------------------
    // Only the low address bits index storage; upper addresses alias
    // Space follows the live select field, so writes and reads always agree
    assign vendor_we = data_access && wb_we_in && lo_wr && !sel_pma;
    assign pma_we = data_access && wb_we_in && lo_wr && sel_pma;

    ext_space_ram u_vendor (
        .clk_sys_in(clk_sys_in),
        .we_in(vendor_we),
        .addr_in(ext_address_q[`STORE_AW-1:0]),
        .wdata_in(wr16),
        .rdata_out(vendor_rd)
    );

    ext_space_ram u_pma (
        .clk_sys_in(clk_sys_in),
        .we_in(pma_we),
        .addr_in(ext_address_q[`STORE_AW-1:0]),
        .wdata_in(wr16),
        .rdata_out(pma_rd)
    );

    // ----------------------------------------------------------------
    // Post-increment decision
    // ----------------------------------------------------------------
    always @* begin
        bump = 1'b0;
        if (data_access) begin
            case (func)
                `FUNC_DATA: bump = 1'b0;
                `FUNC_DATA_INC_ALL: bump = 1'b1;
                `FUNC_DATA_INC_WR: bump = wb_we_in;
                default: bump = 1'b0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Control and address registers
    // ----------------------------------------------------------------
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            ext_access_control_q <= `CTRL_RESET;
            ext_address_q <= `ADDR_RESET;
            ignored_count_q <= `ZERO16;
        end else begin
            if (req && wb_we_in && sel_ctrl && lo_wr) begin
                ext_access_control_q <= wr16;
            end
            if (req && sel_data && !space_ok) begin
                ignored_count_q <= ignored_count_q + `ADDR_STEP;
            end
            if (req && sel_data && space_ok && func == `FUNC_ADDRESS && wb_we_in && lo_wr) begin
                ext_address_q <= wr16;
            end else if (bump) begin
                // Sixteen-bit add wraps naturally
                ext_address_q <= ext_address_q + `ADDR_STEP;
            end
        end
    end

    // ----------------------------------------------------------------
    // Bus answer: writes and register reads ack next edge, storage reads wait a cycle
    // ----------------------------------------------------------------
    reg read_pma_q;

    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= ST_IDLE;
            wb_ack_out <= 1'b0;
            wb_err_out <= 1'b0;
            wb_dat_out <= `ZERO32;
            read_pma_q <= 1'b0;
        end else begin
            wb_ack_out <= 1'b0;
            wb_err_out <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (req) begin
                        if (!(sel_ctrl || sel_data || sel_stat)) begin
                            wb_err_out <= 1'b1;
                            state_q <= ST_DONE;
                        end else if (!wb_we_in && data_access) begin
                            // Storage read needs one more cycle
                            read_pma_q <= sel_pma;
                            state_q <= ST_READ;
                        end else begin
                            wb_ack_out <= 1'b1;
                            state_q <= ST_DONE;
                            wb_dat_out <= `ZERO32;
                            if (!wb_we_in && sel_ctrl) begin
                                wb_dat_out[`REG_WIDTH-1:0] <= ext_access_control_q;
                            end else if (!wb_we_in && sel_stat) begin
                                wb_dat_out[`REG_WIDTH-1:0] <= ignored_count_q;
                            end else if (!wb_we_in && sel_data && space_ok) begin
                                wb_dat_out[`REG_WIDTH-1:0] <= ext_address_q;
                            end
                        end
                    end
                end
                ST_READ: begin
                    wb_dat_out <= `ZERO32;
                    wb_dat_out[`REG_WIDTH-1:0] <= read_pma_q ? pma_rd : vendor_rd;
                    wb_ack_out <= 1'b1;
                    state_q <= ST_DONE;
                end
                ST_DONE: begin
                    // Wait for the master to drop the strobe
                    if (!(wb_cyc_in && wb_stb_in)) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
endmodule // ext_access_top
`default_nettype wire

// >>> ext_access_chk.sv
// Assertions on the bus side of the extended access block.
// Assumes a master that holds each request until ack or err.
`timescale 1ns/1ps
`default_nettype none
`include "ext_access_consts.vh"
module ext_access_chk (
    input wire logic clk_sys_in, // Clock
    input wire logic rst_in, // Reset
    input wire logic wb_cyc_in, // Cycle
    input wire logic wb_stb_in, // Strobe
    input wire logic wb_we_in, // Write
    input wire logic [7:0] wb_adr_in, // Address
    input wire logic [3:0] wb_sel_in, // Selects
    input wire logic [31:0] wb_dat_in, // Write data
    input wire logic [31:0] wb_dat_out, // Read data
    input wire logic wb_ack_out, // Ack
    input wire logic wb_err_out // Error
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    logic [15:0] ctrl_q;
    wire req = wb_cyc_in && wb_stb_in;
    wire valid = ctrl_q[4:0] == `SPACE_VENDOR || ctrl_q[4:0] == `SPACE_PMA;
    wire at_data = wb_adr_in == `OFS_ADDRESS_DATA;
    // Shadow of the control word, so reads can be judged by mode
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in)
            ctrl_q <= `CTRL_RESET;
        else if (wb_ack_out && wb_we_in && wb_adr_in == `OFS_ACCESS_CONTROL && &wb_sel_in[1:0])
            ctrl_q <= wb_dat_in[15:0];
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    AST_ACK_PULSE: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack longer than one cycle");
    AST_ONE_ANSWER: assert property (!(wb_ack_out && wb_err_out))
        else $error("ack and err together");
    AST_WRITE_LAT: assert property ($rose(req) && wb_we_in |=> wb_ack_out || wb_err_out)
        else $error("write not answered next cycle");
    AST_READ_LAT: assert property ($rose(req) && !wb_we_in && at_data && valid
        && ctrl_q[15:14] != `FUNC_ADDRESS |=> !wb_ack_out ##1 wb_ack_out)
        else $error("data read latency wrong");
    AST_IGNORED_ZERO: assert property (wb_ack_out && !wb_we_in && at_data && !valid
        |-> wb_dat_out == 32'h00000000) else $error("ignored read not zero");
    AST_UPPER_ZERO: assert property (wb_ack_out |-> wb_dat_out[31:16] == 16'h0000)
        else $error("upper read bits set");
    AST_NO_SPURIOUS: assert property (!req |=> !wb_ack_out && !wb_err_out)
        else $error("answer without request");
    AST_READ_HOLD: assert property (wb_ack_out && !wb_we_in |=> $stable(wb_dat_out))
        else $error("read data not held");
    cover property ($rose(req) && !wb_we_in && at_data && valid && ctrl_q[15] == 1'b1);
    cover property (wb_err_out);
    cover property (wb_ack_out && at_data && !valid);
endmodule // ext_access_chk
bind ext_access_top ext_access_chk ext_access_chk_i (.clk_sys_in, .rst_in, .wb_cyc_in,
    .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out,
    .wb_err_out);
`default_nettype wire

// >>> mgmt_model.sv
// Management entity model: one classic bus transfer per go pulse.
// Assumes the slave answers each request with a one-cycle ack or err.
`timescale 1ns/1ps
`default_nettype none
module mgmt_model (
    input wire logic clk_sys_in, // Clock
    input wire logic rst_in, // Reset
    input wire logic go_in, // Start a transfer
    input wire logic we_in, // Write request
    input wire logic [7:0] adr_in, // Offset
    input wire logic [31:0] dat_in, // Write data
    input wire logic ack_in, // Slave ack
    input wire logic err_in, // Slave error
    input wire logic [31:0] rdat_in, // Slave read data
    output logic cyc_out, // Cycle and strobe
    output logic we_out, // Write enable
    output logic [7:0] adr_out, // Address
    output logic [3:0] sel_out, // Byte selects
    output logic [31:0] dat_out, // Write data
    output logic done_out, // Transfer over
    output logic err_out, // Ended in error
    output logic [31:0] rdat_out // Captured read data
);
    // ----------------------------------------
    // Bus master
    // ----------------------------------------
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            {cyc_out, we_out, adr_out, sel_out, dat_out, done_out, err_out, rdat_out} <= '0;
        end else if (cyc_out && (ack_in || err_in)) begin
            // Released lines flip so a stale request never looks valid
            cyc_out <= 1'b0;
            {we_out, adr_out, sel_out, dat_out} <= ~{we_out, adr_out, sel_out, dat_out};
            done_out <= 1'b1;
            err_out <= err_in;
            rdat_out <= rdat_in;
        end else begin
            done_out <= 1'b0;
            if (go_in) begin
                {cyc_out, we_out, adr_out, sel_out, dat_out} <= {1'b1, we_in, adr_in, 4'hF, dat_in};
            end
        end
    end
endmodule // mgmt_model
`default_nettype wire

// >>> ext_access_top_tb.sv
// Self-checking bench for the extended access block.
// Assumes the management model issues one transfer at a time.
`timescale 1ns/1ps
`default_nettype none
`include "ext_access_consts.vh"
module ext_access_top_tb;
    localparam logic [7:0] CT = `OFS_ACCESS_CONTROL;
    localparam logic [7:0] AD = `OFS_ADDRESS_DATA;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic go = 1'b0, w = 1'b0, done, bad, cyc, we, ack, err;
    logic [7:0] a = 8'h00, wa;
    logic [3:0] sel;
    logic [31:0] d = 32'h00000000, rdat, wd, dout;
    int fails = 0, n_tests = 0;
    mgmt_model mgmt_model_i (.clk_sys_in, .rst_in, .go_in(go), .we_in(w), .adr_in(a),
        .dat_in(d), .ack_in(ack), .err_in(err), .rdat_in(dout), .cyc_out(cyc), .we_out(we),
        .adr_out(wa), .sel_out(sel), .dat_out(wd), .done_out(done), .err_out(bad),
        .rdat_out(rdat));
    ext_access_top ext_access_top_i (.clk_sys_in, .rst_in, .wb_cyc_in(cyc), .wb_stb_in(cyc),
        .wb_we_in(we), .wb_adr_in(wa), .wb_sel_in(sel), .wb_dat_in(wd), .wb_dat_out(dout),
        .wb_ack_out(ack), .wb_err_out(err));
    initial begin
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end
    task automatic tally_and_finish;
        $display("fails=%0d n_tests=%0d", fails, n_tests);
        if (fails == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Offset 0x00 is unmapped, so only it may end in err
    task automatic bus(input logic wr_en, input logic [7:0] ad, input logic [15:0] v);
        int i;
        go <= 1'b1;
        w <= wr_en;
        a <= ad;
        d <= {16'h0000, v};
        @(posedge clk_sys_in);
        go <= 1'b0;
        for (i = 0; i < 20 && done !== 1'b1; i++)
            @(posedge clk_sys_in);
        n_tests++;
        if (i == 20 || bad !== (ad == 8'h00) || (!wr_en && ad != 8'h00 && rdat !== {16'h0000, v})) begin
            fails++;
            $display("mismatch at %0t: adr %h got %h", $time, ad, rdat);
        end
        if (i == 20)
            tally_and_finish();
    endtask
    task automatic wr(input logic [7:0] ad, input logic [15:0] v); bus(1'b1, ad, v); endtask
    task automatic rd(input logic [7:0] ad, input logic [15:0] v); bus(1'b0, ad, v); endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic s_inc_all;
        rd(CT, 16'h0000);
        wr(CT, 16'h001F);
        wr(AD, 16'h0040);
        rd(AD, 16'h0040);
        wr(CT, 16'h801F);
        for (int k = 0; k < 3; k++) wr(AD, 16'h1000 + k[15:0]);
        wr(CT, 16'h001F);
        rd(AD, 16'h0043);
        wr(AD, 16'h0040);
        wr(CT, 16'h801F);
        for (int k = 0; k < 3; k++) rd(AD, 16'h1000 + k[15:0]);
    endtask
    task automatic s_pma;
        wr(CT, 16'h0001);
        wr(AD, 16'h0050);
        wr(CT, 16'hC001);
        wr(AD, 16'h2222);
        wr(AD, 16'h3333);
        wr(CT, 16'h0001);
        rd(AD, 16'h0052);
        wr(AD, 16'h0051);
        wr(CT, 16'h4001);
        rd(AD, 16'h3333);
        wr(CT, 16'hC001);
        rd(AD, 16'h3333);
        rd(AD, 16'h3333);
        wr(CT, 16'h0001);
        wr(AD, 16'h0050);
        wr(CT, 16'h8001);
        rd(AD, 16'h2222);
        rd(AD, 16'h3333);
    endtask
    task automatic s_wrap;
        wr(CT, 16'h001F);
        wr(AD, 16'hFFFF);
        wr(CT, 16'h401F);
        wr(AD, 16'h1000);
        wr(CT, 16'hC01F);
        rd(AD, 16'h1000);
        wr(AD, 16'h0001);
        wr(CT, 16'h001F);
        rd(AD, 16'h0000);
    endtask
    task automatic s_ignored;
        wr(CT, 16'hC005);
        wr(AD, 16'h1234);
        rd(AD, 16'h0000);
        rd(`OFS_STATUS, 16'h0002);
        wr(CT, 16'h001F);
        rd(AD, 16'h0000);
        rd(8'h00, 16'h0000);
    endtask
    initial begin
        repeat (3) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        s_inc_all();
        s_pma();
        s_wrap();
        s_ignored();
        tally_and_finish();
    end
endmodule // ext_access_top_tb
`default_nettype wire
